// ==== core/cpg_clk_div.sv ====
// Purpose: Integer clock divider producing a clock level from core_clk
// Assumes: ratio is at least 2 and changes only between periods
// Notes:   High for the first half of each period, rounded down
`timescale 1ns/1ps
module cpg_clk_div
  import cpg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [2:0] ratio,
  output logic clk_out
);

  logic [2:0] phase;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase <= 3'h0;
    end else if (!run || phase >= ratio - 3'h1) begin
      phase <= 3'h0;
    end else begin
      phase <= phase + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clk_out <= 1'b0;
    end else if (!run) begin
      clk_out <= 1'b0;
    end else if (phase >= ratio - 3'h1) begin
      clk_out <= 1'b1;
    end else begin
      clk_out <= ((phase + 3'h1) < (ratio >> 1));
    end
  end

endmodule : cpg_clk_div

// ==== core/cpg_pkg.sv ====
// Purpose: Shared constants and types of the clock and core reset generator
// Assumes: core_clk stands in for the reference clock input (10 MHz)
// Notes:   Register offsets are byte addresses on the plain register port
package cpg_pkg;

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] POWER_MGMT_CONTROL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;

  // Field positions inside power_mgmt_control
  localparam int MULT_LSB = 0;
  localparam int MULT_W = 7;
  localparam int PDIV_LSB = 7;
  localparam int INPUT_DIVIDE_ENABLE_BIT = 9;
  localparam int MEMR_LSB = 10;

  // Field positions inside the status word
  localparam int ST_CORE_RUN_BIT = 0;
  localparam int ST_EXT_REL_BIT = 1;
  localparam int ST_MULT_LSB = 8;
  localparam int ST_PDIV_LSB = 16;
  localparam int ST_INPUT_DIVIDE_ENABLE_BIT = 21;

  // ----------------------------------------------------------------------
  // Clock ratios
  // ----------------------------------------------------------------------
  localparam logic [1:0] PDIV_SEL_2 = 2'h0;
  localparam logic [1:0] MEMR_RESET = 2'h0;
  // Memory clock ratio = field + this offset, in core clock periods
  localparam logic [2:0] MEMR_BASE = 3'h2;
  // Multiplier chosen by each strap code; plain defaults
  localparam logic [6:0] STRAP_MULT_0 = 7'h08;
  localparam logic [6:0] STRAP_MULT_1 = 7'h20;
  localparam logic [6:0] STRAP_MULT_2 = 7'h10;
  localparam logic [6:0] STRAP_MULT_3 = 7'h10;
  localparam logic [6:0] MULT_RESET = 7'h08;

  // ----------------------------------------------------------------------
  // Core reset release timing
  // ----------------------------------------------------------------------
  localparam int REF_HZ = 10_000_000;
  localparam int REL_REF_CYCLES = 4096;
  localparam int REL_CORE_CYCLES = 2;
  localparam int REL_CNT_W = 13;
  localparam logic [REL_CNT_W-1:0] REL_TOTAL =
    REL_CNT_W'(REL_REF_CYCLES + REL_CORE_CYCLES);
  // Edges spent by the synchroniser, sequencer entry and output flop;
  // the count stops early by this much so pin-to-core delay stays exact
  localparam int REL_PIPE_CYCLES = 4;

  typedef enum logic [2:0] {
    CPG_HOLD = 3'b001,
    CPG_COUNT = 3'b010,
    CPG_RUN = 3'b100
  } cpg_state_e;

  typedef struct packed {
    logic [1:0] mem_ratio;
    logic in_div;
    logic [1:0] post_div;
    logic [6:0] mult;
  } cpg_ctrl_s;

  // Effective clock configuration shown to the clock tree
  typedef struct packed {
    logic in_div;          // PLL input is reference / 2
    logic [6:0] mult;      // PLL multiplier
    logic [4:0] post_div;  // 2, 4, 8 or 16
    logic [7:0] vco_num;   // VCO = vco_num * f_ref / vco_den
    logic [1:0] vco_den;
    logic [5:0] core_den;  // core = vco_num * f_ref / core_den
  } cpg_cfg_s;

endpackage : cpg_pkg

// ==== core/cpg_top.sv ====
// Purpose: PLL ratio control, derived clocks and core reset release
// Assumes: core_clk is the reference clock; straps synchronous to it
// Notes:   The analog PLL lies outside; this block drives its ratios
//
// Functional notes
// - While external reset holds, multiplier comes from the ratio straps; here it holds MULT_RESET and takes the straps on the two edges after release.
// - Post-divider is 2, 4, 8 or 16; forced to 2 during reset.
// - PLL input is reference clock, or reference over 2 when enabled.
// - VCO is twice multiplier times input; core is VCO over divider.
// - Peripheral clock period is exactly twice the core clock period.
// - Memory clock period is core period times memory clock ratio.
// - Core reset releases 4096 reference plus two core cycles after pin.
// - A missed sampling window may add one reference cycle, 4097 max.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module cpg_top
  import cpg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [1:0] clock_ratio_strap_pins,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output cpg_cfg_s clk_cfg,
  output logic core_rstn,
  output logic peripheral_clk,
  output logic memory_clock
);

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic [6:0] strap_mult(input logic [1:0] code);
    case (code)
      2'h0: strap_mult = STRAP_MULT_0;
      2'h1: strap_mult = STRAP_MULT_1;
      2'h2: strap_mult = STRAP_MULT_2;
      default: strap_mult = STRAP_MULT_3;
    endcase
  endfunction : strap_mult

  function automatic logic [4:0] pdiv_value(input logic [1:0] sel);
    pdiv_value = 5'h02 << sel;
  endfunction : pdiv_value

  // ----------------------------------------------------------------------
  // Reset pin synchroniser
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic ext_released;

  // Deassertion may miss the sampling edge and cost one reference cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      ext_released <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      ext_released <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Core reset release sequencer
  // ----------------------------------------------------------------------
  cpg_state_e state;
  cpg_state_e next_state;
  logic [REL_CNT_W-1:0] rel_cnt;

  always_comb begin
    next_state = state;
    case (state)
      CPG_HOLD: begin
        if (ext_released) begin
          next_state = CPG_COUNT;
        end
      end
      CPG_COUNT: begin
        if (rel_cnt == REL_TOTAL - REL_CNT_W'(REL_PIPE_CYCLES)) begin
          next_state = CPG_RUN;
        end
      end
      CPG_RUN: next_state = CPG_RUN;
      default: next_state = CPG_HOLD;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= CPG_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Counter held clear until the synchronised release, then counts
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rel_cnt <= '0;
    end else if (state != CPG_COUNT) begin
      rel_cnt <= '0;
    end else begin
      rel_cnt <= rel_cnt + REL_CNT_W'(1);
    end
  end

  // 4096 reference cycles then two more for the core clock edges
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      core_rstn <= 1'b0;
    end else begin
      core_rstn <= (next_state == CPG_RUN);
    end
  end

  // ----------------------------------------------------------------------
  // Power management control register
  // ----------------------------------------------------------------------
  cpg_ctrl_s ctrl;
  logic wr_ctrl;

  assign wr_ctrl = reg_wr && (reg_addr == POWER_MGMT_CONTROL_OFS);

  // Straps are sampled on the two edges after the pin releases; last value before ext_released wins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl.mult <= MULT_RESET;
    end else if (!ext_released) begin
      ctrl.mult <= strap_mult(clock_ratio_strap_pins);
    end else if (wr_ctrl) begin
      ctrl.mult <= reg_wdata[MULT_LSB +: MULT_W];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl.post_div <= PDIV_SEL_2;
    end else if (!ext_released) begin
      ctrl.post_div <= PDIV_SEL_2;
    end else if (wr_ctrl) begin
      ctrl.post_div <= reg_wdata[PDIV_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl.in_div <= 1'b0;
      ctrl.mem_ratio <= MEMR_RESET;
    end else if (!ext_released) begin
      ctrl.in_div <= 1'b0;
      ctrl.mem_ratio <= MEMR_RESET;
    end else if (wr_ctrl) begin
      ctrl.in_div <= reg_wdata[INPUT_DIVIDE_ENABLE_BIT];
      ctrl.mem_ratio <= reg_wdata[MEMR_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------------
  // Effective PLL configuration
  // ----------------------------------------------------------------------
  cpg_cfg_s next_cfg;

  // No range check on the multiplier: the VCO limit is software's to keep
  always_comb begin
    next_cfg.in_div = ctrl.in_div;
    next_cfg.mult = ctrl.mult;
    next_cfg.post_div = pdiv_value(ctrl.post_div);
    next_cfg.vco_num = {ctrl.mult, 1'b0};
    next_cfg.vco_den = ctrl.in_div ? 2'h2 : 2'h1;
    next_cfg.core_den = ctrl.in_div ?
      {pdiv_value(ctrl.post_div), 1'b0} :
      {1'b0, pdiv_value(ctrl.post_div)};
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clk_cfg <= '0;
    end else begin
      clk_cfg <= next_cfg;
    end
  end

  // ----------------------------------------------------------------------
  // Derived clocks
  // ----------------------------------------------------------------------
  // Both held low until the core leaves reset; the first memory_clock rise shares its core_clk edge with the first peripheral_clk rise only at ratio 4 or 5
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      peripheral_clk <= 1'b0;
    end else if (!core_rstn) begin
      peripheral_clk <= 1'b0;
    end else begin
      peripheral_clk <= ~peripheral_clk;
    end
  end

  cpg_clk_div u_mem_div (
    .core_clk(core_clk),
    .rstn(rstn),
    .run(core_rstn),
    .ratio(MEMR_BASE + {1'b0, ctrl.mem_ratio}),
    .clk_out(memory_clock)
  );

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        POWER_MGMT_CONTROL_OFS: begin
          next_rdata[MULT_LSB +: MULT_W] = ctrl.mult;
          next_rdata[PDIV_LSB +: 2] = ctrl.post_div;
          next_rdata[INPUT_DIVIDE_ENABLE_BIT] = ctrl.in_div;
          next_rdata[MEMR_LSB +: 2] = ctrl.mem_ratio;
        end
        STATUS_OFS: begin
          next_rdata[ST_CORE_RUN_BIT] = core_rstn;
          next_rdata[ST_EXT_REL_BIT] = ext_released;
          next_rdata[ST_MULT_LSB +: MULT_W] = clk_cfg.mult;
          next_rdata[ST_PDIV_LSB +: 5] = clk_cfg.post_div;
          next_rdata[ST_INPUT_DIVIDE_ENABLE_BIT] = clk_cfg.in_div;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  // Data stand for exactly one cycle after the read strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : cpg_top

// ==== verif/cpg_ext_src.sv ====
// Purpose: Reset source and strap pins outside the generator
// Assumes: Reference clock is the bench clock, always valid
// Notes:   Straps change only while reset is requested
`timescale 1ns/1ps
module cpg_ext_src
  import cpg_pkg::*;
#(
  parameter int LOW_CYC = 200
) (
  input wire logic core_clk,
  input wire logic rst_req,
  input wire logic [1:0] strap_code,
  output logic rstn = 1'b0,
  output logic [1:0] clock_ratio_strap_pins = 2'h0
);
  // --------------------------------------------------------------------
  // Pin hold: 200 cycles cover the four-cycle pulse and 20 us setup
  // --------------------------------------------------------------------
  int low_cnt = 0;
  always @(posedge core_clk) begin
    if (rst_req) begin
      rstn <= 1'b0;
      low_cnt <= 0;
      clock_ratio_strap_pins <= strap_code;
    end else if (low_cnt < LOW_CYC) begin
      low_cnt <= low_cnt + 1;
    end else begin
      rstn <= 1'b1;
    end
  end
endmodule : cpg_ext_src

// ==== verif/cpg_top_properties.sv ====
// Purpose: Port assertions for the clock and core reset generator
// Assumes: One clock domain; rstn asynchronous, active low
// Notes:   Memory clock period is measured by the bench instead
`timescale 1ns/1ps
module cpg_top_props
  import cpg_pkg::*;
(
  input logic core_clk,
  input logic rstn,
  input logic [1:0] clock_ratio_strap_pins,
  input logic reg_rd,
  input logic [DATA_W-1:0] reg_rdata,
  input cpg_cfg_s clk_cfg,
  input logic core_rstn,
  input logic peripheral_clk,
  input logic memory_clock
);
  // --------------------------------------------------------------------
  // Helpers and properties
  // --------------------------------------------------------------------
  logic [12:0] rel_cnt;
  logic [6:0] smap;
  assign smap = clock_ratio_strap_pins[1] ?
    (clock_ratio_strap_pins[0] ? STRAP_MULT_3 : STRAP_MULT_2) :
    (clock_ratio_strap_pins[0] ? STRAP_MULT_1 : STRAP_MULT_0);
  // Edges seen since the pin released while core reset still holds
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rel_cnt <= '0;
    end else if (!core_rstn) begin
      rel_cnt <= rel_cnt + 13'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_strap; $rose(rstn) |-> ##2 clk_cfg.mult == smap; endproperty
  a_strap: assert property (p_strap) else $error("strap mult");
  property p_div_rst;
    $rose(rstn) |-> ##2 (clk_cfg.post_div == 5'h02 && !clk_cfg.in_div);
  endproperty
  a_div_rst: assert property (p_div_rst) else $error("reset div");
  property p_div_set;
    core_rstn |-> clk_cfg.post_div inside {5'h02, 5'h04, 5'h08, 5'h10};
  endproperty
  a_div_set: assert property (p_div_set) else $error("post div");
  property p_in_div;
    core_rstn |-> clk_cfg.vco_den == (clk_cfg.in_div ? 2'h2 : 2'h1);
  endproperty
  a_in_div: assert property (p_in_div) else $error("in div");
  property p_vco; core_rstn |-> clk_cfg.vco_num == {clk_cfg.mult, 1'b0};
  endproperty
  a_vco: assert property (p_vco) else $error("vco num");
  property p_core;
    core_rstn |-> clk_cfg.core_den ==
      6'(clk_cfg.post_div) * 6'(clk_cfg.vco_den);
  endproperty
  a_core: assert property (p_core) else $error("core den");
  property p_pclk;
    core_rstn && $past(core_rstn, 2) |->
      peripheral_clk != $past(peripheral_clk);
  endproperty
  a_pclk: assert property (p_pclk) else $error("pclk");
  property p_rel; $rose(core_rstn) |-> rel_cnt inside {[13'h1002:13'h1003]};
  endproperty
  a_rel: assert property (p_rel) else $error("release");
  property p_stay; core_rstn |=> core_rstn; endproperty
  a_stay: assert property (p_stay) else $error("core reset dropped");
  property p_rd; !$past(reg_rd) |-> reg_rdata == '0; endproperty
  a_rd: assert property (p_rd) else $error("stale read data");
  c_rel: cover property ($rose(core_rstn));
  c_rd: cover property (reg_rd);
  c_mem: cover property ($rose(memory_clock));
endmodule : cpg_top_props
bind cpg_top cpg_top_props cpg_top_props_i (.core_clk, .rstn,
  .clock_ratio_strap_pins, .reg_rd, .reg_rdata, .clk_cfg, .core_rstn,
  .peripheral_clk, .memory_clock);

// ==== verif/cpg_top_tb_top.sv ====
// Purpose: Directed bench for the clock and core reset generator
// Assumes: Reset source model drives rstn and the strap pins
// Notes:   Release time is counted from the pin edge to core_rstn
`timescale 1ns/1ps
module cpg_top_tb_top
  import cpg_pkg::*;
;
  // --------------------------------------------------------------------
  // Harness
  // --------------------------------------------------------------------
  localparam logic [6:0] SMAP [4] =
    '{STRAP_MULT_0, STRAP_MULT_1, STRAP_MULT_2, STRAP_MULT_3};
  logic core_clk, rst_req, reg_wr, reg_rd;
  logic [1:0] strap_code, pins;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
  logic rstn, core_rstn, peripheral_clk, memory_clock;
  logic [6:0] m;
  logic [4:0] p;
  cpg_cfg_s clk_cfg;
  int bad_count = 0, n_compared = 0, n;
  cpg_ext_src cpg_ext_src_i (.core_clk(core_clk), .rst_req(rst_req),
    .strap_code(strap_code), .rstn(rstn), .clock_ratio_strap_pins(pins));
  cpg_top cpg_top_i (.core_clk(core_clk), .rstn(rstn),
    .clock_ratio_strap_pins(pins), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .clk_cfg(clk_cfg), .core_rstn(core_rstn),
    .peripheral_clk(peripheral_clk), .memory_clock(memory_clock));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task end_sim;
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  task chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk32
  task chk_n(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("[ERR] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_n
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
  // Waits on a level with a bound; 1 means core reset, 0 the pin
  task wait_hi(input bit core, input int lim, output int c);
    c = 0;
    while ((core ? core_rstn : rstn) !== 1'b1 && c < lim) begin
      @(posedge core_clk);
      #1;
      c++;
    end
  endtask : wait_hi
  // A second reset in mid-count must restart the release delay
  task reset_run(input logic [1:0] code, input int tries);
    for (int k = 0; k < tries; k++) begin
      strap_code <= code;
      rst_req <= 1'b1;
      repeat (5) @(posedge core_clk);
      rst_req <= 1'b0;
      wait_hi(1'b0, 400, n);
      if (k < tries - 1) repeat (1000) @(posedge core_clk);
    end
    wait_hi(1'b1, 5000, n);
    chk_n(n, 4098, 4099);
  endtask : reset_run
  // Period of the peripheral (1) or memory (0) clock in core cycles
  task period(input bit sel, output int c);
    c = 0;
    for (int k = 0; k < 4; k++) begin
      while ((sel ? peripheral_clk : memory_clock) !== k[0] && c < 100) begin
        @(posedge core_clk);
        #1;
        c++;
      end
      if (k == 1) c = 0;
    end
  endtask : period
  function automatic logic [31:0] st(logic [6:0] mm, logic [4:0] pp, logic i);
    return {10'h0, i, pp, 1'b0, mm, 6'h0, 2'h3};
  endfunction : st
  initial begin
    #(100 * 40000);
    bad_count++;
    end_sim();
  end
  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    {rst_req, reg_wr, reg_rd} = 3'b100;
    strap_code = 2'h0;
    reg_addr = '0;
    reg_wdata = '0;
    for (int s = 0; s < 4; s++) begin
      reset_run(2'(s), (s == 2) ? 2 : 1);
      rd(STATUS_OFS, d);
      chk32(d, st(SMAP[s], 5'h02, 1'b0));
      rd(POWER_MGMT_CONTROL_OFS, d);
      chk32(d, 32'(SMAP[s]));
    end
    for (int i = 0; i < 8; i++) begin
      m = 7'(5 + i);
      p = 5'h02 << i[1:0];
      wr(POWER_MGMT_CONTROL_OFS, 32'({i[1:0], i[2], i[1:0], m}));
      rd(STATUS_OFS, d);
      chk32(d, st(m, p, i[2]));
      chk32(32'(clk_cfg), 32'({i[2], m, p, m, 1'b0, i[2] ? 2'h2 : 2'h1,
        6'(p * (i[2] ? 2 : 1))}));
      rd(POWER_MGMT_CONTROL_OFS, d);
      chk32(d, 32'({i[1:0], i[2], i[1:0], m}));
      repeat (12) @(posedge core_clk);
      period(1'b0, n);
      chk_n(n, MEMR_BASE + i[1:0], MEMR_BASE + i[1:0]);
    end
    period(1'b1, n);
    chk_n(n, 2, 2);
    wr(4'h8, 32'hffffffff);
    rd(4'h8, d);
    chk32(d, 32'h0);
    end_sim();
  end
endmodule : cpg_top_tb_top
